/* rtl/bcd_adjust_and_decrement_unit.sv */
// Four-phase sequencer for the decimal adjust and file decrement instructions
//
// Summary of operation
// - Low nibble above nine or half carry set: add six to low nibble.
// - High nibble above nine or carry set: add six to high nibble.
// - Otherwise the low nibble goes back to the accumulator unchanged.
// - Decrement reads the file register, subtracts one, sends result onward.
// - Destination bit zero: result to accumulator, file register untouched.
// - Destination bit one: result written back to the same file register.
// - Bank bit zero: use the fixed access bank, ignore bank select.
// - Bank bit one: address built from the bank select register value.
// - File field spans 0 to 255; destination and bank fields are one bit.
//
// Strobed register access and the register offsets are this design's own decisions.
`include "bdu_map.svh"
module bcd_adjust_and_decrement_unit (
	input wire logic clk, // Core clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic instr_valid, // Instruction word offered
	input wire logic [15:0] instr_word, // Instruction word
	input wire bdu_pkg::bdu_bank_t bank_sel, // Current bank select register value
	input wire bdu_pkg::bdu_byte_t w_in, // Current accumulator value
	input wire bdu_pkg::bdu_flags_t status_in, // Current status flags
	output logic rf_rd_en, // File register read strobe
	output bdu_pkg::bdu_addr_t rf_addr, // File register address
	input wire bdu_pkg::bdu_byte_t rf_rd_data, // File read data, one cycle after strobe
	output logic rf_wr_en, // File register write strobe
	output bdu_pkg::bdu_byte_t rf_wr_data, // File register write data
	output logic w_wr_en, // Accumulator write strobe
	output bdu_pkg::bdu_byte_t w_wr_data, // Accumulator write data
	output logic status_wr_en, // Status write strobe
	output bdu_pkg::bdu_flags_t status_wr_mask, // Flags that the write changes
	output bdu_pkg::bdu_flags_t status_wr_data, // New flag values
	output logic instr_ready, // Unit can take an instruction now
	output logic instr_done, // Pulse in the write phase of a finished instruction
	output logic instr_bad // Pulse when the offered word is not handled here
);
	import bdu_pkg::*;

	// ============================================================
	// Address formation

	// Access bank maps the low half of the field to one bank and the high half to another
	function automatic bdu_addr_t bdu_file_addr(input logic use_bank, input bdu_bank_t bank,
		input bdu_byte_t f);
		if (use_bank) begin
			bdu_file_addr = {bank, f};
		end else if (f < `BDU_ACCESS_SPLIT) begin
			bdu_file_addr = {`BDU_ACCESS_LO_BANK, f};
		end else begin
			bdu_file_addr = {`BDU_ACCESS_HI_BANK, f};
		end
	endfunction

	// ============================================================
	// State and datapath registers

	bdu_state_t state_r;
	bdu_state_t state_nxt;
	logic [15:0] ir_r;
	logic [15:0] ir_nxt;
	bdu_op_t op_r;
	bdu_op_t op_nxt;
	logic dest_file_r;
	logic dest_file_nxt;
	bdu_byte_t operand_r;
	bdu_byte_t operand_nxt;
	bdu_flags_t flags_r;
	bdu_flags_t flags_nxt;
	bdu_addr_t addr_r;
	bdu_addr_t addr_nxt;
	logic rd_en_r;
	logic rd_en_nxt;
	logic rf_wr_r;
	logic rf_wr_nxt;
	logic w_wr_r;
	logic w_wr_nxt;
	logic st_wr_r;
	logic st_wr_nxt;
	bdu_byte_t res_r;
	bdu_byte_t res_nxt;
	bdu_flags_t mask_r;
	bdu_flags_t mask_nxt;
	bdu_flags_t sflags_r;
	bdu_flags_t sflags_nxt;
	logic done_r;
	logic done_nxt;
	logic bad_r;
	logic bad_nxt;
	logic take;

	bdu_alu_if alu_bus ();

	bdu_alu u_alu (
		.bus(alu_bus)
	);

	// Operands reach the core in the processing phase; file data stands only then, so it is
	// fed straight from the port rather than through a register that would lag a cycle
	assign alu_bus.op = op_r;
	assign alu_bus.operand = (op_r == BDU_OP_DEC) ? rf_rd_data : operand_r;
	assign alu_bus.flags_in = flags_r;

	// A new word may enter while idle or in the last phase, so cycles run back to back
	assign instr_ready = (state_r == BDU_IDLE) || (state_r == BDU_Q4);
	assign take = instr_valid && instr_ready;

	// ============================================================
	// Next-state and datapath computation

	// Phase sequencing and each phase's work
	always_comb begin
		state_nxt = state_r;
		ir_nxt = ir_r;
		op_nxt = op_r;
		dest_file_nxt = dest_file_r;
		operand_nxt = operand_r;
		flags_nxt = flags_r;
		addr_nxt = addr_r;
		rd_en_nxt = 1'b0;
		rf_wr_nxt = 1'b0;
		w_wr_nxt = 1'b0;
		st_wr_nxt = 1'b0;
		res_nxt = res_r;
		mask_nxt = mask_r;
		sflags_nxt = sflags_r;
		done_nxt = 1'b0;
		bad_nxt = 1'b0;
		case (state_r)
			BDU_IDLE: begin
				if (take) begin
					ir_nxt = instr_word;
					state_nxt = BDU_Q1;
				end
			end
			BDU_Q1: begin
				// Decode: fixed word for the adjust, six-bit prefix for the decrement
				if (ir_r == `BDU_OP_ADJ_WORD) begin
					op_nxt = BDU_OP_ADJ;
					dest_file_nxt = 1'b0;
					rd_en_nxt = 1'b0;
					state_nxt = BDU_Q2;
				end else if (ir_r[`BDU_OP_DEC_HI:`BDU_OP_DEC_LO] == `BDU_OP_DEC_CODE) begin
					op_nxt = BDU_OP_DEC;
					dest_file_nxt = ir_r[`BDU_DEST_BIT];
					// Full eight-bit field, so every file address 0..255 is reachable
					addr_nxt = bdu_file_addr(ir_r[`BDU_BANK_BIT], bank_sel,
						ir_r[`BDU_FILE_HI:`BDU_FILE_LO]);
					rd_en_nxt = 1'b1;
					state_nxt = BDU_Q2;
				end else begin
					// Not ours: drop it and flag it, no register or flag is touched
					op_nxt = BDU_OP_NONE;
					bad_nxt = 1'b1;
					state_nxt = BDU_IDLE;
				end
			end
			BDU_Q2: begin
				// Read phase: flags, and for the adjust the accumulator, are sampled now, after any prior write
				flags_nxt = status_in[`BDU_FLAG_W-1:0];
				if (op_r == BDU_OP_ADJ) begin
					operand_nxt = w_in;
				end
				state_nxt = BDU_Q3;
			end
			BDU_Q3: begin
				// File data returns now, one cycle after the strobe, and feeds the core directly
				state_nxt = BDU_Q4;
			end
			BDU_Q4: begin
				done_nxt = 1'b0;
				if (take) begin
					ir_nxt = instr_word;
					state_nxt = BDU_Q1;
				end else begin
					state_nxt = BDU_IDLE;
				end
			end
			default: begin
				state_nxt = BDU_IDLE;
			end
		endcase
		// Process phase result is captured on entry to the write phase
		if (state_r == BDU_Q3) begin
			res_nxt = alu_bus.result;
			mask_nxt = alu_bus.flags_mask;
			sflags_nxt = alu_bus.flags_out;
			st_wr_nxt = 1'b1;
			done_nxt = 1'b1;
			if (op_r == BDU_OP_ADJ) begin
				w_wr_nxt = 1'b1;
			end else if (dest_file_r) begin
				rf_wr_nxt = 1'b1;
			end else begin
				w_wr_nxt = 1'b1;
			end
		end
	end

	// Registers only; reset parks the unit idle with every strobe low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= BDU_IDLE;
			ir_r <= `BDU_RST_WORD;
			op_r <= BDU_OP_NONE;
			dest_file_r <= 1'b0;
			operand_r <= `BDU_RST_BYTE;
			flags_r <= `BDU_RST_FLAGS;
			addr_r <= `BDU_RST_ADDR;
			rd_en_r <= 1'b0;
			rf_wr_r <= 1'b0;
			w_wr_r <= 1'b0;
			st_wr_r <= 1'b0;
			res_r <= `BDU_RST_BYTE;
			mask_r <= `BDU_RST_FLAGS;
			sflags_r <= `BDU_RST_FLAGS;
			done_r <= 1'b0;
			bad_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ir_r <= ir_nxt;
			op_r <= op_nxt;
			dest_file_r <= dest_file_nxt;
			operand_r <= operand_nxt;
			flags_r <= flags_nxt;
			addr_r <= addr_nxt;
			rd_en_r <= rd_en_nxt;
			rf_wr_r <= rf_wr_nxt;
			w_wr_r <= w_wr_nxt;
			st_wr_r <= st_wr_nxt;
			res_r <= res_nxt;
			mask_r <= mask_nxt;
			sflags_r <= sflags_nxt;
			done_r <= done_nxt;
			bad_r <= bad_nxt;
		end
	end

	// ============================================================
	// Outputs, all from flip-flops except the ready handshake

	// Address is held through the write phase so one port serves read and write-back
	assign rf_rd_en = rd_en_r;
	assign rf_addr = addr_r;
	assign rf_wr_en = rf_wr_r;
	assign rf_wr_data = res_r;
	assign w_wr_en = w_wr_r;
	assign w_wr_data = res_r;
	assign status_wr_en = st_wr_r;
	assign status_wr_mask = mask_r;
	assign status_wr_data = sflags_r;
	assign instr_done = done_r;
	assign instr_bad = bad_r;
endmodule

/* rtl/bdu_map.svh */
// Opcode fields, flag positions, address layout and reset values of the adjust/decrement unit
`ifndef BDU_MAP_SVH
`define BDU_MAP_SVH

// ============================================================
// Instruction encodings
`define BDU_OP_ADJ_WORD 16'h0007
`define BDU_OP_DEC_HI 15
`define BDU_OP_DEC_LO 10
`define BDU_OP_DEC_CODE 6'h01
`define BDU_DEST_BIT 9
`define BDU_BANK_BIT 8
`define BDU_FILE_HI 7
`define BDU_FILE_LO 0

// ============================================================
// Status flag bit positions
`define BDU_FLAG_C 0
`define BDU_FLAG_HC 1
`define BDU_FLAG_Z 2
`define BDU_FLAG_V 3
`define BDU_FLAG_N 4
`define BDU_FLAG_W 5

// ============================================================
// Arithmetic constants
`define BDU_NIBBLE_MAX 4'h9
`define BDU_BCD_FIX_LO 9'h006
`define BDU_BCD_FIX_HI 9'h060
`define BDU_DEC_ADDEND 9'h0FF
`define BDU_SIGN_MIN 8'h80

// ============================================================
// File-register addressing: access bank splits into a low and a high bank
`define BDU_ADDR_W 12
`define BDU_BANK_W 4
`define BDU_ACCESS_SPLIT 8'h80
`define BDU_ACCESS_LO_BANK 4'h0
`define BDU_ACCESS_HI_BANK 4'hF

// ============================================================
// Reset values
`define BDU_RST_BYTE 8'h00
`define BDU_RST_WORD 16'h0000
`define BDU_RST_FLAGS 5'h00
`define BDU_RST_ADDR 12'h000

`endif

/* rtl/bdu_pkg.sv */
// Types shared by the adjust/decrement unit and its arithmetic core
package bdu_pkg;
`include "bdu_map.svh"

	typedef logic [7:0] bdu_byte_t;
	typedef logic [`BDU_FLAG_W-1:0] bdu_flags_t;
	typedef logic [`BDU_ADDR_W-1:0] bdu_addr_t;
	typedef logic [`BDU_BANK_W-1:0] bdu_bank_t;

	// One phase per state; idle follows the last phase only when no new word is taken
	typedef enum logic [4:0] {
		BDU_IDLE = 5'b0_0001,
		BDU_Q1 = 5'b0_0010,
		BDU_Q2 = 5'b0_0100,
		BDU_Q3 = 5'b0_1000,
		BDU_Q4 = 5'b1_0000
	} bdu_state_t;

	// Operation selected by the decoder
	typedef enum logic [2:0] {
		BDU_OP_NONE = 3'b001,
		BDU_OP_ADJ = 3'b010,
		BDU_OP_DEC = 3'b100
	} bdu_op_t;
endpackage

/* rtl/bdu_alu_if.sv */
// Carrier between the sequencer and the arithmetic core
interface bdu_alu_if;
	import bdu_pkg::*;
	bdu_op_t op;
	bdu_byte_t operand;
	bdu_flags_t flags_in;
	bdu_byte_t result;
	bdu_flags_t flags_out;
	bdu_flags_t flags_mask;

	modport seq (output op, output operand, output flags_in,
		input result, input flags_out, input flags_mask);
	modport alu (input op, input operand, input flags_in,
		output result, output flags_out, output flags_mask);
endinterface

/* rtl/bdu_alu.sv */
// Combinational arithmetic for the decimal adjust and the file decrement
`include "bdu_map.svh"
module bdu_alu (
	bdu_alu_if.alu bus // Operation, operand and results
);
	import bdu_pkg::*;

	// Flags of one nibble test, shared by both corrections
	function automatic logic bdu_over_nine(input logic [3:0] nib);
		bdu_over_nine = nib > `BDU_NIBBLE_MAX;
	endfunction

	logic [8:0] lo_sum;
	logic [8:0] hi_sum;
	logic [8:0] dec_sum;
	logic lo_fix;
	logic hi_fix;

	// Both corrections in one chain: the low fix may carry into the high nibble
	always_comb begin
		lo_fix = bdu_over_nine(bus.operand[3:0]) | bus.flags_in[`BDU_FLAG_HC];
		lo_sum = {1'b0, bus.operand} + (lo_fix ? `BDU_BCD_FIX_LO : 9'h000);
		hi_fix = bdu_over_nine(lo_sum[7:4]) | bus.flags_in[`BDU_FLAG_C] | lo_sum[8];
		hi_sum = lo_sum + (hi_fix ? `BDU_BCD_FIX_HI : 9'h000);
		dec_sum = {1'b0, bus.operand} + `BDU_DEC_ADDEND;
	end

	// Result and flag selection; unused operations leave all flags untouched
	always_comb begin
		bus.result = bus.operand;
		bus.flags_out = bus.flags_in;
		bus.flags_mask = `BDU_RST_FLAGS;
		case (bus.op)
			BDU_OP_ADJ: begin
				bus.result = hi_sum[7:0];
				// Carry stays set once set: an earlier decimal carry is never undone
				bus.flags_out[`BDU_FLAG_C] = hi_sum[8] | bus.flags_in[`BDU_FLAG_C];
				bus.flags_mask[`BDU_FLAG_C] = 1'b1;
			end
			BDU_OP_DEC: begin
				bus.result = dec_sum[7:0];
				bus.flags_out[`BDU_FLAG_C] = dec_sum[8];
				bus.flags_out[`BDU_FLAG_HC] = bus.operand[3:0] != 4'h0;
				bus.flags_out[`BDU_FLAG_Z] = dec_sum[7:0] == `BDU_RST_BYTE;
				bus.flags_out[`BDU_FLAG_V] = bus.operand == `BDU_SIGN_MIN;
				bus.flags_out[`BDU_FLAG_N] = dec_sum[7];
				bus.flags_mask = {`BDU_FLAG_W{1'b1}};
			end
			default: begin
				bus.result = bus.operand;
			end
		endcase
	end
endmodule

/* verif/bdu_asserts.sv */
// Port checker for the adjust/decrement unit, bound to its top module
// ============================================================
// Checker
module bdu_asserts (
	input wire logic clk, // Core clock
	input wire logic nrst, // Reset, active low
	input wire logic [15:0] instr_word, // Offered word
	input wire bdu_pkg::bdu_bank_t bank_sel, // Bank select
	input wire bdu_pkg::bdu_flags_t status_in, // Flags in
	input wire logic rf_rd_en, // File read
	input wire bdu_pkg::bdu_addr_t rf_addr, // File address
	input wire bdu_pkg::bdu_byte_t rf_rd_data, // File data
	input wire logic rf_wr_en, // File write
	input wire bdu_pkg::bdu_byte_t rf_wr_data, // File write data
	input wire logic w_wr_en, // Accumulator write
	input wire bdu_pkg::bdu_byte_t w_wr_data, // Accumulator data
	input wire logic status_wr_en, // Flag write
	input wire bdu_pkg::bdu_flags_t status_wr_mask, // Flag mask
	input wire bdu_pkg::bdu_flags_t status_wr_data, // Flag data
	input wire logic instr_ready, // Ready
	input wire logic instr_done, // Done
	input wire logic instr_bad // Unhandled
);
	timeunit 1ns;
	timeprecision 1ps;
	import bdu_pkg::*;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// The taken word sits two edges before the read strobe
	AST_RD_TO_DONE: assert property (rf_rd_en |->
		##2 instr_done && status_wr_mask == 5'h1f)
		else $error("decrement did not finish two cycles after its read");
	AST_DEC_RESULT: assert property (rf_rd_en |-> ##2
		(rf_wr_en ? rf_wr_data : w_wr_data) == $past(rf_rd_data) - 8'h01)
		else $error("decrement result is not file data minus one");
	AST_DEST_ONE: assert property (rf_rd_en && $past(instr_word[9], 2) |->
		##2 rf_wr_en && !w_wr_en)
		else $error("destination one did not write the file register");
	AST_DEST_ZERO: assert property (rf_rd_en && !$past(instr_word[9], 2) |->
		##2 w_wr_en && !rf_wr_en)
		else $error("destination zero did not write the accumulator only");
	AST_ADDR_BANK: assert property (rf_rd_en && $past(instr_word[8], 2) |->
		rf_addr == {$past(bank_sel), $past(instr_word[7:0], 2)})
		else $error("banked address not built from bank select");
	AST_ADDR_ACCESS: assert property (rf_rd_en && !$past(instr_word[8], 2) |->
		rf_addr == {{4{$past(instr_word[7], 2)}}, $past(instr_word[7:0], 2)})
		else $error("access bank address wrong");
	AST_ADDR_HOLD: assert property (rf_rd_en |=> $stable(rf_addr) [*2])
		else $error("file address moved before the write phase");
	AST_ADJ_MASK: assert property (w_wr_en && !$past(rf_rd_en, 2) |->
		status_wr_mask == 5'h01)
		else $error("adjust changed flags other than carry");
	AST_ADJ_CARRY: assert property (status_wr_en && status_wr_mask == 5'h01 &&
		$past(status_in[0], 2) |-> status_wr_data[0])
		else $error("adjust cleared a set carry");
	AST_SPACING: assert property (instr_done |=> !instr_done [*3])
		else $error("instructions closer than four cycles");
	AST_DONE_READY: assert property (instr_done |-> instr_ready && status_wr_en)
		else $error("write phase without ready or flag write");
	AST_BAD_QUIET: assert property (instr_bad |-> !rf_rd_en && !instr_done ##1 !instr_done)
		else $error("unhandled word produced activity");
endmodule

bind bcd_adjust_and_decrement_unit bdu_asserts u_chk (.clk(clk), .nrst(nrst),
	.instr_word(instr_word), .bank_sel(bank_sel), .status_in(status_in), .rf_rd_en(rf_rd_en),
	.rf_addr(rf_addr), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en), .rf_wr_data(rf_wr_data),
	.w_wr_en(w_wr_en), .w_wr_data(w_wr_data), .status_wr_en(status_wr_en),
	.status_wr_mask(status_wr_mask), .status_wr_data(status_wr_data),
	.instr_ready(instr_ready), .instr_done(instr_done), .instr_bad(instr_bad));

/* verif/testbench.sv */
// Self-checking bench for the adjust/decrement unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bdu_pkg::*;
	// ============================================================
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	bdu_bank_t bank_sel = 4'h0;
	bdu_byte_t w_in = 8'h00, rf_rd_data = 8'h00, fdata = 8'h00;
	bdu_flags_t status_in = 5'h00;
	logic rf_rd_en, rf_wr_en, w_wr_en, status_wr_en, instr_ready, instr_done, instr_bad;
	bdu_addr_t rf_addr, s_addr;
	bdu_byte_t rf_wr_data, w_wr_data, s_rfd, s_wd;
	bdu_flags_t status_wr_mask, status_wr_data, s_mask, s_sd;
	logic s_rfw, s_ww;
	int failures = 0;
	int compares = 0;
	int rd_cyc, done_cyc, bad_cyc;
	bcd_adjust_and_decrement_unit dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
		.instr_word(instr_word), .bank_sel(bank_sel), .w_in(w_in), .status_in(status_in),
		.rf_rd_en(rf_rd_en), .rf_addr(rf_addr), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
		.rf_wr_data(rf_wr_data), .w_wr_en(w_wr_en), .w_wr_data(w_wr_data),
		.status_wr_en(status_wr_en), .status_wr_mask(status_wr_mask),
		.status_wr_data(status_wr_data), .instr_ready(instr_ready), .instr_done(instr_done),
		.instr_bad(instr_bad));
	// 100 MHz clock
	initial forever #5 clk = ~clk;
	// File answers only after a strobe; otherwise the inverse, so stale data cannot pass
	always @(posedge clk) rf_rd_data <= rf_rd_en ? fdata : ~fdata;
	// ============================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (failures == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Offer one word, then record what the six following cycles show
	task automatic run(input logic [15:0] word, input bdu_bank_t bank, input bdu_byte_t w,
		input bdu_flags_t st, input bdu_byte_t f);
		int n;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= word;
		bank_sel <= bank;
		w_in <= w;
		status_in <= st;
		fdata <= f;
		#1;
		for (n = 0; n < 20 && instr_ready !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 20) begin
			failures++;
			close_out();
		end
		@(posedge clk);
		instr_valid <= 1'b0;
		rd_cyc = -1;
		done_cyc = -1;
		bad_cyc = -1;
		for (n = 1; n <= 6; n++) begin
			#1;
			if (rf_rd_en === 1'b1) begin
				rd_cyc = n;
				s_addr = rf_addr;
			end
			if (instr_bad === 1'b1) bad_cyc = n;
			if (instr_done === 1'b1) begin
				done_cyc = n;
				{s_rfw, s_ww, s_rfd, s_wd} = {rf_wr_en, w_wr_en, rf_wr_data, w_wr_data};
				{s_mask, s_sd} = {status_wr_mask, status_wr_data};
			end
			@(posedge clk);
		end
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset();
		#1;
		check({rf_rd_en, rf_wr_en, w_wr_en, status_wr_en, instr_done, instr_ready}, 6'h01);
		check({w_wr_data, rf_wr_data}, 16'h0000);
	endtask
	// Entries: accumulator, half carry, carry, expected accumulator, expected carry
	task automatic t_adjust();
		logic [18:0] tab [6] = '{{8'ha5, 2'b00, 8'h05, 1'b1}, {8'hce, 2'b00, 8'h34, 1'b1},
			{8'h12, 2'b00, 8'h12, 1'b0}, {8'h12, 2'b10, 8'h18, 1'b0},
			{8'h12, 2'b01, 8'h72, 1'b1}, {8'h39, 2'b00, 8'h39, 1'b0}};
		for (int i = 0; i < 6; i++) begin
			run(16'h0007, 4'h3, tab[i][18:11], {3'b101, tab[i][10:9]}, 8'h00);
			check({rd_cyc[1:0], done_cyc[2:0]}, 5'h1c);
			check({s_ww, s_rfw, s_wd}, {2'b10, tab[i][8:1]});
			check({s_mask, s_sd}, {5'h01, 3'b101, tab[i][10], tab[i][0]});
		end
	endtask
	task automatic t_decrement_file_reg();
		logic [7:0] fv [4] = '{8'h00, 8'h01, 8'h80, 8'h10};
		logic [7:0] f, r;
		for (int i = 0; i < 8; i++) begin
			f = fv[i / 2];
			r = f - 8'h01;
			run({6'h01, i[0], 1'b1, 8'h33}, 4'h2, 8'h5a, 5'h00, f);
			check({rd_cyc[2:0], done_cyc[2:0]}, 6'h14);
			check(s_addr, 12'h233);
			check({s_rfw, s_ww}, {i[0], ~i[0]});
			check(i[0] ? s_rfd : s_wd, r);
			check({s_mask, s_sd}, {5'h1f, r[7], f == 8'h80, r == 0, f[3:0] != 0, f != 0});
		end
	endtask
	// Entries: bank select, bank bit, file field, expected address
	task automatic t_bank();
		logic [24:0] tab [5] = '{{4'h5, 1'b1, 8'h80, 12'h580}, {4'h5, 1'b0, 8'h7f, 12'h07f},
			{4'h5, 1'b0, 8'h80, 12'hf80}, {4'ha, 1'b0, 8'hff, 12'hfff}, {4'ha, 1'b1, 8'h00, 12'ha00}};
		for (int i = 0; i < 5; i++) begin
			run({6'h01, 1'b0, tab[i][20], tab[i][19:12]}, tab[i][24:21], 8'h00, 5'h00, 8'h44);
			check(s_addr, tab[i][11:0]);
			check({s_rfw, s_ww, s_wd}, 10'h143);
		end
	endtask
	// Valid held through three takes: one finish every four cycles
	task automatic t_b2b();
		int dones;
		dones = 0;
		@(posedge clk);
		instr_word <= 16'h0007;
		instr_valid <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			if (n == 9) instr_valid <= 1'b0;
			#1;
			if (instr_done === 1'b1) dones++;
			@(posedge clk);
		end
		check(dones, 3);
	endtask
	task automatic t_bad();
		logic [15:0] wd [2] = '{16'h0008, 16'h0800};
		for (int i = 0; i < 2; i++) begin
			run(wd[i], 4'h0, 8'h00, 5'h00, 8'h00);
			check({bad_cyc[2:0], done_cyc[2:0], rd_cyc[2:0]}, 9'h0bf);
		end
	endtask
	// ============================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_adjust();
		t_decrement_file_reg();
		t_bank();
		t_b2b();
		t_bad();
		close_out();
	end
endmodule
